//--- logic/fbcsm_pkg.sv
// constants shared by the flash bank command host controller
`default_nettype none
package fbcsm_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 21;                 // word address plus byte lsb
  localparam int DATA_W = 16;
  localparam int BANK_BIT = 20;               // top address bit picks bank
  // ==========================================================
  // timing, ns and derived cycles at 50 MHz
  localparam int CLK_NS = 20;
  localparam int T_WP_NS = 60;                // write strobe low, least
  localparam int T_WPH_NS = 40;               // write strobe high, least
  localparam int T_ACC_NS = 120;              // read access, least wait
  localparam int T_RP_NS = 500;               // reset pin low, least
  localparam int T_RH_NS = 200;               // reset recovery, least
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 6;
  // ==========================================================
  // command cycles on the flash pins
  localparam logic [11:0] UNLOCK1_W = 12'h555;
  localparam logic [11:0] UNLOCK2_W = 12'h2aa;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYP_RST1 = 8'h90;
  localparam logic [7:0] CMD_BYP_RST2 = 8'h00;
  localparam logic [7:0] CMD_SEC_ENTER = 8'h88;  // plain default
  localparam logic [7:0] CMD_SEC_EXIT = 8'h90;   // plain default
  localparam logic [7:0] CMD_SEC_EXIT2 = 8'h00;  // plain default
  // status bits of the flash data bus
  localparam int POLL_BIT = 7;
  localparam int ERR_BIT = 5;
  // ==========================================================
  // software register map of the controller
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_HWRST = 8'h18;
  localparam logic [3:0] CFG_RESET = 4'h0;
  // ==========================================================
  // operations software may order
  typedef enum logic [3:0] {
    OP_RESET      = 4'b0000,
    OP_IDENT      = 4'b0001,
    OP_READ       = 4'b0010,
    OP_PROGRAM    = 4'b0011,
    OP_BYP_ENTER  = 4'b0100,
    OP_BYP_PROG   = 4'b0101,
    OP_BYP_RESET  = 4'b0110,
    OP_SEC_ENTER  = 4'b0111,
    OP_SEC_EXIT   = 4'b1000
  } fbcsm_op_t;
  // mode of one bank as the host tracks it
  typedef enum logic [1:0] {
    MODE_READ   = 2'b00,
    MODE_IDENT  = 2'b01,
    MODE_BYPASS = 2'b10
  } fbcsm_mode_t;
endpackage
`default_nettype wire

//--- logic/fbcsm_bus_cycle.sv
// one asynchronous write or read cycle on the flash pins
`default_nettype none
module fbcsm_bus_cycle
  import fbcsm_pkg::*;
(
  input  wire logic                 clk_sys,     // system clock
  input  wire logic                 sys_rst,     // async reset
  input  wire logic                 abort,       // drop cycle now
  input  wire logic                 start,       // begin one cycle
  input  wire logic                 isWrite,     // write, else read
  input  wire logic [ADDR_W-1:0]    addrIn,      // cycle address
  input  wire logic [DATA_W-1:0]    dataIn,      // write data
  output logic                      done,        // cycle finished
  output logic [DATA_W-1:0]         rdata,       // sampled read data
  output logic [ADDR_W-1:0]         flashAddr,   // flash address pins
  output logic [DATA_W-1:0]         flashDqOut,  // data pins out
  output logic                      flashDqOe,   // data pins driven
  input  wire logic [DATA_W-1:0]    flashDqIn,   // data pins in
  output logic                      flashCeN,    // chip enable
  output logic                      flashWeN,    // write enable
  output logic                      flashOeN     // output enable
);
  typedef enum logic [1:0] {
    BC_IDLE   = 2'b00,
    BC_SETUP  = 2'b01,
    BC_STROBE = 2'b10,
    BC_HOLD   = 2'b11
  } fbcsm_bc_t;

  fbcsm_bc_t        state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             wr_reg;

  wire logic [CNT_W-1:0] strobeLen = wr_reg ? CNT_W'(WP_CYC)
                                            : CNT_W'(ACC_CYC);
  wire logic             cntEnd = (cnt_reg == strobeLen - 1'b1);
  wire logic             holdEnd = (cnt_reg == CNT_W'(WPH_CYC - 1));

  // ==========================================================
  // cycle sequencer: address set before the falling strobe, data
  // held past the rising one so both latch edges see stable values
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg  <= BC_IDLE;
      cnt_reg    <= '0;
      wr_reg     <= 1'b0;
      done       <= 1'b0;
      rdata      <= '0;
      flashAddr  <= '0;
      flashDqOut <= '0;
      flashDqOe  <= 1'b0;
      flashCeN   <= 1'b1;
      flashWeN   <= 1'b1;
      flashOeN   <= 1'b1;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state_reg <= BC_IDLE;
        flashDqOe <= 1'b0;
        flashCeN  <= 1'b1;
        flashWeN  <= 1'b1;
        flashOeN  <= 1'b1;
      end else begin
        case (state_reg)
          BC_IDLE: begin
            if (start) begin
              wr_reg     <= isWrite;
              flashAddr  <= addrIn;
              flashDqOut <= dataIn;
              flashDqOe  <= isWrite;
              flashCeN   <= 1'b0;
              state_reg  <= BC_SETUP;
            end
          end
          BC_SETUP: begin
            cnt_reg   <= '0;
            flashWeN  <= ~wr_reg;
            flashOeN  <= wr_reg;
            state_reg <= BC_STROBE;
          end
          BC_STROBE: begin
            cnt_reg <= cnt_reg + 1'b1;
            if (cntEnd) begin
              if (!wr_reg) begin
                rdata <= flashDqIn;
              end
              flashWeN  <= 1'b1;
              flashOeN  <= 1'b1;
              cnt_reg   <= '0;
              state_reg <= BC_HOLD;
            end
          end
          BC_HOLD: begin
            cnt_reg  <= cnt_reg + 1'b1;
            flashCeN <= 1'b1;
            if (holdEnd) begin
              flashDqOe <= 1'b0;
              done      <= 1'b1;
              state_reg <= BC_IDLE;
            end
          end
          default: state_reg <= BC_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/fbcsm_host.sv
// host controller issuing flash bank command sequences
//
// Decided for this implementation: the plain strobed port and the register addresses.
`default_nettype none
// What this block does
// - ident is unlock, unlock, bank plus command
// - no ident unless the target bank is in read mode
// - program is four cycles, width by pin
// - bypass entered with 20h, program with A0h
// - bypass accepts only program, 90h/00h reset and array read
module fbcsm_host
  import fbcsm_pkg::*;
(
  input  wire logic                          clk_sys,    // 50 MHz
  input  wire logic                          sys_rst,    // async reset
  input  wire logic [7:0]                    regAddr,    // register address
  input  wire logic [31:0]                   regWdata,   // write data
  input  wire logic                          regWr,      // write strobe
  input  wire logic                          regRd,      // read strobe
  output logic [31:0]                        regRdata,   // data next cycle
  output logic [fbcsm_pkg::ADDR_W-1:0]       flashAddr,  // address pins
  output logic [fbcsm_pkg::DATA_W-1:0]       flashDqOut, // data out
  output logic                               flashDqOe,  // data driven
  input  wire logic [fbcsm_pkg::DATA_W-1:0]  flashDqIn,  // data in
  output logic                               flashCeN,   // chip enable
  output logic                               flashWeN,   // write enable
  output logic                               flashOeN,   // output enable
  output logic                               flashRstN,  // hardware reset
  output logic                               flashByteN, // low = byte
  output logic                               flashAccHv, // acc high volt
  input  wire logic                          flashRyBy   // ready/busy
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CYC   = 3'b001,
    ST_WAIT  = 3'b010,
    ST_POLL  = 3'b011,
    ST_PWAIT = 3'b100,
    ST_RSTLO = 3'b101,
    ST_RSTHI = 3'b110
  } fbcsm_st_t;

  fbcsm_st_t        state_reg;
  fbcsm_op_t        op_reg;
  logic [2:0]       step_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [3:0]       cfg_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rd_reg;
  fbcsm_mode_t      mode0_reg;
  fbcsm_mode_t      mode1_reg;
  logic             secure_reg;
  logic             err_reg;
  logic             refused_reg;
  logic             dq5Seen_reg;
  logic             bcStart;
  logic             bcDone;
  logic [DATA_W-1:0] bcRdata;

  // ==========================================================
  // decode of the software port and of the current target
  wire logic        byteMode = cfg_reg[0];
  wire logic        accOn = cfg_reg[1];
  wire logic        cmdWr = regWr && (regAddr == REG_CMD);
  wire logic        hwRstWr = regWr && (regAddr == REG_HWRST);
  wire fbcsm_op_t   newOp = fbcsm_op_t'(regWdata[3:0]);
  wire logic        bankSel = addr_reg[BANK_BIT];
  wire fbcsm_mode_t bankMode = bankSel ? mode1_reg : mode0_reg;
  // acceleration voltage puts every bank into bypass by itself
  wire logic        inBypass = (bankMode == MODE_BYPASS) || accOn;
  wire logic        idleNow = (state_reg == ST_IDLE);
  // bypass admits only its own program and reset, plus array reads
  wire logic        opLegal =
      inBypass ? (newOp == OP_BYP_PROG || newOp == OP_BYP_RESET ||
                  newOp == OP_READ)
    : (newOp == OP_IDENT) ? (bankMode == MODE_READ)
    : (newOp == OP_BYP_PROG || newOp == OP_BYP_RESET) ? 1'b0
    : (newOp <= OP_SEC_EXIT);
  wire logic        accept = cmdWr && idleNow && opLegal;

  // unlock addresses move up one bit in byte mode
  wire logic [ADDR_W-1:0] unl1 = byteMode ? ADDR_W'({UNLOCK1_W, 1'b0})
                                          : ADDR_W'(UNLOCK1_W);
  wire logic [ADDR_W-1:0] unl2 = byteMode ? ADDR_W'({UNLOCK2_W, 1'b1})
                                          : ADDR_W'(UNLOCK2_W);
  wire logic [ADDR_W-1:0] bankBase =
      {addr_reg[ADDR_W-1:BANK_BIT], {BANK_BIT{1'b0}}};

  // ==========================================================
  // sequence table: cycle address, data, kind and length per op
  logic [ADDR_W-1:0] seqAddr;
  logic [7:0]        seqData;
  logic              seqWrite;
  logic [2:0]        seqLen;
  logic              seqFull;   // last cycle carries user data
  always_comb begin
    seqAddr  = unl1;
    seqData  = CMD_UNLOCK1;
    seqWrite = 1'b1;
    seqLen   = 3'd3;
    seqFull  = 1'b0;
    if (step_reg == 3'd1) begin
      seqAddr = unl2;
      seqData = CMD_UNLOCK2;
    end
    // third cycle carries the bank so the device picks the right bank
    if (step_reg == 3'd2) seqAddr = bankBase | unl1;
    case (op_reg)
      OP_RESET: begin
        seqLen  = 3'd1;
        seqData = CMD_RESET;
      end
      OP_IDENT: if (step_reg == 3'd2) seqData = CMD_IDENT;
      OP_READ: begin
        seqLen   = 3'd1;
        seqAddr  = addr_reg;
        seqWrite = 1'b0;
      end
      OP_PROGRAM: begin
        seqLen = 3'd4;
        if (step_reg == 3'd2) seqData = CMD_PROGRAM;
        if (step_reg == 3'd3) begin
          seqAddr = addr_reg;
          seqFull = 1'b1;
        end
      end
      OP_BYP_ENTER: if (step_reg == 3'd2) seqData = CMD_BYPASS;
      OP_BYP_PROG: begin
        seqLen  = 3'd2;
        seqAddr = addr_reg;
        seqData = CMD_PROGRAM;
        seqFull = (step_reg == 3'd1);
      end
      OP_BYP_RESET: begin
        seqLen  = 3'd2;
        seqAddr = bankBase;
        seqData = (step_reg == 3'd0) ? CMD_BYP_RST1 : CMD_BYP_RST2;
      end
      OP_SEC_ENTER: if (step_reg == 3'd2) seqData = CMD_SEC_ENTER;
      OP_SEC_EXIT: begin
        seqLen = 3'd4;
        if (step_reg == 3'd2) seqData = CMD_SEC_EXIT;
        if (step_reg == 3'd3) seqData = CMD_SEC_EXIT2;
      end
      default: seqLen = 3'd1;
    endcase
  end

  wire logic [DATA_W-1:0] cycData = seqFull ? wdata_reg
                                            : DATA_W'(seqData);
  wire logic lastStep = (step_reg == seqLen - 3'd1);
  wire logic isProg = (op_reg == OP_PROGRAM) || (op_reg == OP_BYP_PROG);
  // width of compare follows the byte pin
  wire logic [DATA_W-1:0] cmpMask = byteMode ? DATA_W'(8'hff) : '1;
  wire logic pollMatch =
      bcRdata[POLL_BIT] == wdata_reg[POLL_BIT];
  wire logic verifyBad =
      |((bcRdata ^ wdata_reg) & cmpMask);
  wire logic rstOp = (op_reg == OP_RESET) || (op_reg == OP_BYP_RESET);
  // a reset or a standard program lands the bank back in read mode; a bypass program leaves it in bypass
  wire fbcsm_mode_t afterMode =
      (op_reg == OP_IDENT) ? MODE_IDENT
    : (op_reg == OP_BYP_ENTER) ? MODE_BYPASS
    : (rstOp || isProg) ? MODE_READ
    : bankMode;

  assign bcStart = (state_reg == ST_CYC) || (state_reg == ST_POLL);

  fbcsm_bus_cycle u_cycle (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .abort      (hwRstWr),
    .start      (bcStart),
    .isWrite    ((state_reg == ST_CYC) && seqWrite),
    .addrIn     ((state_reg == ST_POLL) ? addr_reg : seqAddr),
    .dataIn     (cycData),
    .done       (bcDone),
    .rdata      (bcRdata),
    .flashAddr  (flashAddr),
    .flashDqOut (flashDqOut),
    .flashDqOe  (flashDqOe),
    .flashDqIn  (flashDqIn),
    .flashCeN   (flashCeN),
    .flashWeN   (flashWeN),
    .flashOeN   (flashOeN)
  );

  // ==========================================================
  // operation sequencer; no command leaves while a program runs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      op_reg      <= OP_RESET;
      step_reg    <= '0;
      cnt_reg     <= '0;
      mode0_reg   <= MODE_READ;
      mode1_reg   <= MODE_READ;
      secure_reg  <= 1'b0;
      err_reg     <= 1'b0;
      refused_reg <= 1'b0;
      dq5Seen_reg <= 1'b0;
      rd_reg      <= '0;
      flashRstN   <= 1'b1;
    end else if (hwRstWr) begin
      state_reg  <= ST_RSTLO;
      cnt_reg    <= '0;
      flashRstN  <= 1'b0;
      mode0_reg  <= MODE_READ;
      mode1_reg  <= MODE_READ;
      secure_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmdWr) begin
            refused_reg <= !opLegal;
          end
          if (accept) begin
            op_reg      <= newOp;
            step_reg    <= '0;
            err_reg     <= 1'b0;
            dq5Seen_reg <= 1'b0;
            state_reg   <= ST_CYC;
          end
        end
        ST_CYC: state_reg <= ST_WAIT;
        ST_WAIT: if (bcDone) begin
          step_reg <= step_reg + 3'd1;
          if (!seqWrite) begin
            rd_reg <= bcRdata & cmpMask;
          end
          if (!lastStep) begin
            state_reg <= ST_CYC;
          end else if (isProg) begin
            state_reg <= ST_POLL;
          end else begin
            state_reg <= ST_IDLE;
            if (bankSel || op_reg == OP_RESET) mode1_reg <= afterMode;
            if (!bankSel || op_reg == OP_RESET) mode0_reg <= afterMode;
            if (op_reg == OP_SEC_ENTER) secure_reg <= 1'b1;
            if (op_reg == OP_SEC_EXIT) secure_reg <= 1'b0;
          end
        end
        ST_POLL: state_reg <= ST_PWAIT;
        ST_PWAIT: if (bcDone) begin
          rd_reg <= bcRdata & cmpMask;
          if (pollMatch) begin
            err_reg   <= verifyBad;
            state_reg <= ST_IDLE;
            if (op_reg == OP_PROGRAM) begin
              if (bankSel) mode1_reg <= MODE_READ;
              else mode0_reg <= MODE_READ;
            end
          end else if (bcRdata[ERR_BIT] && dq5Seen_reg) begin
            // error flag stuck: device needs a reset to recover
            err_reg   <= 1'b1;
            op_reg    <= OP_RESET;
            step_reg  <= '0;
            state_reg <= ST_CYC;
          end else begin
            dq5Seen_reg <= bcRdata[ERR_BIT];
            state_reg   <= ST_POLL;
          end
        end
        ST_RSTLO: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RP_CYC - 1)) begin
            cnt_reg   <= '0;
            flashRstN <= 1'b1;
            state_reg <= ST_RSTHI;
          end
        end
        ST_RSTHI: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RH_CYC - 1)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // configuration, target and read-back registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg   <= CFG_RESET;
      addr_reg  <= '0;
      wdata_reg <= '0;
      regRdata  <= '0;
    end else begin
      // target registers only change while no sequence uses them
      if (regWr && idleNow && regAddr == REG_CFG) cfg_reg <= regWdata[3:0];
      if (regWr && idleNow && regAddr == REG_ADDR) begin
        addr_reg <= regWdata[ADDR_W-1:0];
      end
      if (regWr && idleNow && regAddr == REG_WDATA) begin
        wdata_reg <= regWdata[DATA_W-1:0];
      end
      regRdata <= '0;
      if (regRd) begin
        case (regAddr)
          REG_CFG:    regRdata <= {28'h0000000, cfg_reg};
          REG_ADDR:   regRdata <= {11'h000, addr_reg};
          REG_WDATA:  regRdata <= {16'h0000, wdata_reg};
          REG_RDATA:  regRdata <= {16'h0000, rd_reg};
          REG_STATUS: regRdata <= {22'h000000, accOn, secure_reg,
                                   mode1_reg, mode0_reg, flashRyBy,
                                   refused_reg, err_reg, !idleNow};
          default:    regRdata <= '0;
        endcase
      end
    end
  end

  assign flashByteN = !byteMode;
  assign flashAccHv = accOn;
endmodule
`default_nettype wire

//--- verif/fbcsm_host_assertions.sv
// port checks for the flash bank host controller
`default_nettype none
module fbcsm_host_checker
  import fbcsm_pkg::*;
(
  input wire logic                        clk_sys,   // clock
  input wire logic                        sys_rst,   // reset
  input wire logic [7:0]                  regAddr,   // reg address
  input wire logic                        regWr,     // reg write
  input wire logic [fbcsm_pkg::ADDR_W-1:0] flashAddr, // address pins
  input wire logic                        flashCeN,  // chip enable
  input wire logic                        flashWeN,  // write enable
  input wire logic                        flashOeN,  // output enable
  input wire logic                        flashDqOe, // data driven
  input wire logic                        flashRstN  // pin reset
);
  // ==========================================================
  // strobe shapes on the flash pins
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_we; !flashWeN [*3] ##1 flashWeN; endsequence
  sequence s_oe; !flashOeN [*6] ##1 flashOeN; endsequence
  property p_we; $fell(flashWeN) |-> s_we; endproperty
  a_we: assert property (p_we) else $error("we width");
  property p_oe; $fell(flashOeN) |-> s_oe; endproperty
  a_oe: assert property (p_oe) else $error("oe width");
  property p_frame; !flashWeN |-> !flashCeN && flashDqOe && flashOeN;
  endproperty
  a_frame: assert property (p_frame) else $error("we frame");
  // address must not move while the chip is selected
  property p_addr; !flashCeN && !$past(flashCeN) |-> $stable(flashAddr);
  endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
  property p_setup; $fell(flashWeN) |-> !$past(flashCeN); endproperty
  a_setup: assert property (p_setup) else $error("ce setup");
  property p_end; $rose(flashWeN) |=> $rose(flashCeN); endproperty
  a_end: assert property (p_end) else $error("ce release");
  // pin reset is prompt and long enough
  property p_hw; regWr && regAddr == REG_HWRST |-> ##[1:4] !flashRstN;
  endproperty
  a_hw: assert property (p_hw) else $error("no pin reset");
  property p_rst; $fell(flashRstN) |-> !flashRstN [*8]; endproperty
  a_rst: assert property (p_rst) else $error("reset short");
endmodule
bind fbcsm_host fbcsm_host_checker u_fbcsm_host_checker (.clk_sys,
  .sys_rst, .regAddr, .regWr, .flashAddr, .flashCeN, .flashWeN,
  .flashOeN, .flashDqOe, .flashRstN);
`default_nettype wire

//--- verif/fbcsm_flash_model.sv
// behavioural flash device facing the host controller
`default_nettype none
module fbcsm_flash_model #(
  parameter logic [15:0] MAKER = 16'h00a5, // arbitrary maker code
  parameter logic [15:0] DEVID = 16'h5a3c, // arbitrary device code
  parameter int          PROG  = 30        // program time, 20 ns steps
) (
  input  wire logic [20:0] addr,  // address pins
  input  wire logic [15:0] dqIn,  // data from host
  output logic      [15:0] dqOut, // data to host
  input  wire logic        ceN,   // chip enable
  input  wire logic        weN,   // write enable
  input  wire logic        oeN,   // output enable
  input  wire logic        rstN,  // pin reset
  input  wire logic        accHv, // acceleration voltage
  output logic             ryBy   // ready, not busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:1023];
  logic [1:0]  mode [0:1];
  logic [15:0] pd, rd, lastQ;
  logic [2:0]  st;
  logic        sec, err;
  int          bsy;
  wire  [9:0]  ix = {sec, addr[20], addr[7:0]};
  wire         b = addr[20];
  wire  [7:0]  d = dqIn[7:0];
  // ==========================================================
  // all banks reading, nothing running
  task automatic clr;
    mode = '{2'h0, 2'h0};
    st = 3'h0;
    sec = 1'b0;
    err = 1'b0;
    bsy = 0;
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    pd = 16'h0;
    lastQ = 16'h0;
    clr();
  end
  always @(negedge rstN) clr();
  always #20 if (bsy > 0) bsy = bsy - 1;
  // data taken as write strobe rises; busy ignores all writes
  always @(posedge weN) if (!ceN && rstN && bsy == 0) begin
    if (err) err = (d != 8'hf0);
    else if (st == 3'h3) begin
      pd = dqIn;
      err = (mem[ix] & pd) != pd;
      mem[ix] = mem[ix] & pd;
      bsy = err ? 0 : PROG;
      st = 3'h0;
    end else if (mode[b] == 2'h2 || accHv) begin
      if (d == 8'ha0) st = 3'h3;
      else if (st != 3'h4) st = (d == 8'h90) ? 3'h4 : 3'h0;
      else begin
        st = 3'h0;
        if (d == 8'h00) mode[b] = 2'h0;
      end
    end else if (d == 8'hf0) begin
      st = 3'h0;
      mode = '{2'h0, 2'h0};
    end else if (st < 3'h2) begin
      st = (addr[11:0] == (st[0] ? 12'h2aa : 12'h555) &&
            d == (st[0] ? 8'h55 : 8'haa)) ? st + 3'h1 : 3'h0;
    end else if (st == 3'h2) begin
      st = (d == 8'ha0) ? 3'h3 : (d == 8'h90 && sec) ? 3'h5 : 3'h0;
      if (d == 8'h90 && !sec) mode[b] = 2'h1;
      if (d == 8'h20) mode[b] = 2'h2;
      if (d == 8'h88) sec = 1'b1;
    end else begin
      if (st == 3'h5 && d == 8'h00) sec = 1'b0;
      st = 3'h0;
    end
  end
  // poll word while busy or after a failed program, id table in ident mode, else array
  always_comb begin
    rd = mem[ix];
    if (bsy > 0 || err) rd = {8'h00, ~pd[7], 1'b0, err, 5'h00};
    else if (mode[b] == 2'h1)
      rd = addr[1] ? (addr[0] ? 16'h0085 : 16'h0000)
                   : (addr[0] ? DEVID : MAKER);
  end
  always @(posedge oeN) lastQ = rd;
  // released bus shows the inverse, never a stale copy
  assign dqOut = (!ceN && !oeN) ? rd : ~lastQ;
  assign ryBy = (bsy == 0);
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the flash bank host controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fbcsm_pkg::*;
  localparam logic [15:0] MK = 16'h00a5; // arbitrary maker code
  localparam logic [15:0] DV = 16'h5a3c; // arbitrary device code
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata, v;
  logic [20:0] flashAddr;
  logic [15:0] flashDqOut, flashDqIn, d1, d2;
  logic        flashDqOe, flashCeN, flashWeN, flashOeN, flashRstN;
  logic        flashByteN, flashAccHv, flashRyBy;
  int          n_errors = 0;
  int          num_checks = 0;
  int          seed = 44229;
  always #10 clk_sys = ~clk_sys;
  fbcsm_host u_fbcsm_host (.clk_sys, .sys_rst, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .flashAddr, .flashDqOut, .flashDqOe,
    .flashDqIn, .flashCeN, .flashWeN, .flashOeN, .flashRstN,
    .flashByteN, .flashAccHv, .flashRyBy);
  fbcsm_flash_model #(.MAKER(MK), .DEVID(DV)) u_fbcsm_flash_model (
    .addr(flashAddr), .dqIn(flashDqOut), .dqOut(flashDqIn),
    .ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN), .rstN(flashRstN),
    .accHv(flashAccHv), .ryBy(flashRyBy));
  // ==========================================================
  // verdict, compare and register bus helpers
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= dat;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic idle;
    for (int i = 0; i < 500; i++) begin
      rd(REG_STATUS);
      if (v[0] === 1'b0) return;
    end
    n_errors++;
    end_sim();
  endtask
  task automatic op(input logic [3:0] o, input logic [20:0] a,
                    input logic [15:0] dat);
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'(dat));
    wr(REG_CMD, 32'(o));
    idle();
  endtask
  task automatic rdf(input logic [20:0] a, input logic [15:0] e);
    op(OP_READ, a, 16'h0);
    rd(REG_RDATA);
    chk(v, 32'(e));
  endtask
  function automatic logic [15:0] idv(input int i);
    return i == 0 ? MK : i == 1 ? DV : i == 2 ? 16'h0000 : 16'h0085;
  endfunction
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(REG_STATUS);
    chk(v & 32'h1fd, 32'h8);
    rd(8'h1c);
    chk(v, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      d1 = 16'($random(seed));
      d2 = k[0] ? 16'($random(seed)) : d1 & 16'($random(seed));
      op(OP_PROGRAM, 21'(4 * k), d1);
      op(OP_PROGRAM, 21'(4 * k), d2);
      rd(REG_STATUS);
      chk(32'(v[1]), 32'((d1 & d2) != d2));
      rdf(21'(4 * k), d1 & d2);
    end
    $display("program test done");
    op(OP_IDENT, 21'h100000, 16'h0);
    rd(REG_STATUS);
    chk(32'(v[7:4]), 32'h4);
    for (int k = 0; k < 8; k++)
      rdf(21'h100000 + 21'(k % 4), idv(k % 4));
    op(OP_RESET, 21'h0, 16'h0);
    rd(REG_STATUS);
    chk(32'(v[7:4]), 32'h0);
    $display("ident test done");
    for (int j = 0; j < 2; j++) begin
      if (j == 0) op(OP_BYP_ENTER, 21'h40, 16'h0);
      else wr(REG_CFG, 32'h2);
      op(OP_PROGRAM, 21'h40, 16'h0);
      rd(REG_STATUS);
      chk(32'(v[2]), 32'h1);
      d1 = 16'($random(seed));
      op(OP_BYP_PROG, 21'(8'h40 + 4 * j), d1);
      rdf(21'(8'h40 + 4 * j), d1);
      if (j == 1) wr(REG_CFG, 32'h0);
      else op(OP_BYP_RESET, 21'h40, 16'h0);
    end
    rd(REG_STATUS);
    chk(32'(v[5:4]), 32'h0);
    $display("bypass test done");
    d1 = 16'($random(seed));
    op(OP_SEC_ENTER, 21'h0, 16'h0);
    op(OP_PROGRAM, 21'h48, d1);
    rdf(21'h48, d1);
    op(OP_SEC_EXIT, 21'h0, 16'h0);
    rdf(21'h48, 16'hffff);
    wr(REG_CFG, 32'hd);
    rd(REG_CFG);
    chk({flashByteN, v[30:0]}, 32'hd);
    rdf(21'h48, 16'h00ff);
    wr(REG_CFG, 32'h0);
    $display("secure test done");
    op(OP_BYP_ENTER, 21'h100000, 16'h0);
    rd(REG_STATUS);
    chk(32'(v[7:4]), 32'h8);
    wr(REG_HWRST, 32'h1);
    idle();
    rd(REG_STATUS);
    chk(32'(v[8:4]), 32'h0);
    $display("hardware reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
